// File: shared/bcrb_params.svh
// Offsets, reset values and timing counts of the basic config bank
`ifndef BCRB_PARAMS_SVH
`define BCRB_PARAMS_SVH
// ==========================================================
// Register word indices, compared with byte address bits 7:2
`define BCRB_OFS_BASE   6'h00
`define BCRB_OFS_LIMIT  6'h01
`define BCRB_OFS_MACH   6'h02
`define BCRB_OFS_TOUT   6'h03
`define BCRB_OFS_MONEY  6'h04
`define BCRB_OFS_PUNCT  6'h05
`define BCRB_OFS_RDLIM  6'h06
`define BCRB_OFS_WRLIM  6'h07
`define BCRB_OFS_MKLIM  6'h08
`define BCRB_OFS_STAT   6'h09
// ==========================================================
// Status bit positions
`define BCRB_ST_VIS     0
`define BCRB_ST_BUSY    1
`define BCRB_ST_RDERR   2
`define BCRB_ST_WRERR   3
`define BCRB_ST_RUN     4
// ==========================================================
// Generation/load defaults
`define BCRB_MACH_RST   2'h3
`define BCRB_TOUT_RST   8'h1D
`define BCRB_MONEY_RST  8'h24
`define BCRB_PUNCT_RST  1'h0
`define BCRB_RDLIM_RST  4'h6
`define BCRB_WRLIM_RST  3'h4
`define BCRB_WRLIM_MAX  3'h4
`define BCRB_MKLIM_RST  2'h2
// ==========================================================
// Timing
`define BCRB_CLK_MHZ    250
`define BCRB_TICK_MS    41
`define BCRB_TICK_CYC   (`BCRB_TICK_MS * `BCRB_CLK_MHZ * 1000)
`endif

// File: shared/bcrb_pkg.sv
// Types of the basic config bank
package bcrb_pkg;
  // ========================================================
  // Retry engine states, one-hot
  typedef enum logic [1:0] {
    BCRB_IDLE = 2'b01,
    BCRB_WAIT = 2'b10
  } bcrb_fsm_t;
  // Cassette operation kinds
  typedef enum logic [1:0] {
    BCRB_OP_READ  = 2'b00,
    BCRB_OP_WRITE = 2'b01,
    BCRB_OP_MARK  = 2'b10
  } bcrb_op_t;
  // ========================================================
  // Bus and side-band carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } bcrb_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } bcrb_wb_rsp_t;
  typedef struct packed {
    logic     start;
    bcrb_op_t kind;
    logic     ok;
    logic     fail;
  } bcrb_tape_req_t;
  typedef struct packed {
    logic busy;
    logic retry;
    logic done;
    logic rd_err;
    logic wr_err;
  } bcrb_tape_rsp_t;
  typedef struct packed {
    logic [15:0] base;
    logic [15:0] limit;
    logic [1:0]  mach;
    logic [7:0]  money;
    logic        punct;
    logic        vis;
  } bcrb_cfg_t;
  // ========================================================
  // Whole module state
  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [15:0] base;
    logic [15:0] limit;
    logic [1:0]  mach;
    logic [7:0]  tout;
    logic [7:0]  money;
    logic        punct;
    logic [3:0]  rd_lim;
    logic [2:0]  wr_lim;
    logic [1:0]  mk_lim;
    logic [23:0] pre;
    logic [7:0]  ticks;
    logic        vis;
    bcrb_fsm_t   fsm;
    bcrb_op_t    kind;
    logic [3:0]  lim;
    logic [3:0]  cnt;
    logic        retry;
    logic        done;
    logic        rd_err;
    logic        wr_err;
    logic        rd_err_st;
    logic        wr_err_st;
    logic        run;
  } bcrb_state_t;
endpackage

// File: rtl/bcrb_top.sv
// Basic configuration register bank with print-head timer and retry engine
// Contract
// - Hold 16-bit user memory base, load-set, read-only
// - Hold 16-bit user memory limit, load-set, read-only
// - 2-bit field selects interpreted language
// - Language field defaults to binary 11
// - Timeout counts 41 ms units before visibility mode
// - Zero timeout never enters visibility mode
// - Timeout defaults to about 1.2 seconds
// - Legacy object load forces timeout to zero
// - 8-bit money guard character, default 24
// - 1-bit punctuation style, default zero
// - Read retried up to 4-bit limit, then error
// - Read retry limit defaults to six
// - Write retried up to limit 0..4, then error
// - Tape-mark writes use only their own limit
// - Write retry limit defaults to four
// - Tape-mark retried up to 2-bit limit, then error
// - Tape-mark retry limit defaults to two
// - First program key leaves configuration unchanged
`timescale 1ns/1ps
`include "bcrb_params.svh"
module bcrb_top #(
  parameter int TICK_CYCLES = `BCRB_TICK_CYC
) (
  input  wire logic                    CLOCK_I,
  input  wire logic                    RST_N_I,
  input  wire logic                    CE_I,
  input  wire bcrb_pkg::bcrb_wb_req_t  WB_I,
  output      bcrb_pkg::bcrb_wb_rsp_t  WB_O,
  input  wire logic                    GEN_LOAD_I,
  input  wire logic                    LEGACY_I,
  input  wire logic [15:0]             USER_BASE_I,
  input  wire logic [15:0]             USER_LIMIT_I,
  input  wire logic                    FIRST_KEY_I,
  input  wire logic                    PRINT_BUSY_I,
  input  wire bcrb_pkg::bcrb_tape_req_t TAPE_I,
  output      bcrb_pkg::bcrb_tape_rsp_t TAPE_O,
  output      bcrb_pkg::bcrb_cfg_t     CFG_O
);
  import bcrb_pkg::*;

  // ========================================================
  // State register and reset image
  bcrb_state_t s_q;
  bcrb_state_t s_d;
  localparam bcrb_state_t RST_S = '{
    ack: 1'b0, rdat: 32'h0000_0000,
    base: 16'h0000, limit: 16'h0000,
    mach: `BCRB_MACH_RST, tout: `BCRB_TOUT_RST,
    money: `BCRB_MONEY_RST, punct: `BCRB_PUNCT_RST,
    rd_lim: `BCRB_RDLIM_RST, wr_lim: `BCRB_WRLIM_RST,
    mk_lim: `BCRB_MKLIM_RST,
    pre: 24'h00_0000, ticks: 8'h00, vis: 1'b0,
    fsm: BCRB_IDLE, kind: BCRB_OP_READ,
    lim: 4'h0, cnt: 4'h0,
    retry: 1'b0, done: 1'b0, rd_err: 1'b0, wr_err: 1'b0,
    rd_err_st: 1'b0, wr_err_st: 1'b0, run: 1'b0
  };

  // Last prescaler value of one 41 ms unit
  localparam logic [23:0] PRE_LAST = 24'(TICK_CYCLES - 1);

  // ========================================================
  // Read data multiplexer
  function automatic logic [31:0] rd_word(
    input bcrb_state_t s,
    input logic [5:0]  idx
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx == `BCRB_OFS_BASE)
      w[15:0] = s.base;
    else if (idx == `BCRB_OFS_LIMIT)
      w[15:0] = s.limit;
    else if (idx == `BCRB_OFS_MACH)
      w[1:0] = s.mach;
    else if (idx == `BCRB_OFS_TOUT)
      w[7:0] = s.tout;
    else if (idx == `BCRB_OFS_MONEY)
      w[7:0] = s.money;
    else if (idx == `BCRB_OFS_PUNCT)
      w[0] = s.punct;
    else if (idx == `BCRB_OFS_RDLIM)
      w[3:0] = s.rd_lim;
    else if (idx == `BCRB_OFS_WRLIM)
      w[2:0] = s.wr_lim;
    else if (idx == `BCRB_OFS_MKLIM)
      w[1:0] = s.mk_lim;
    else if (idx == `BCRB_OFS_STAT)
    begin
      w[`BCRB_ST_VIS]   = s.vis;
      w[`BCRB_ST_BUSY]  = (s.fsm == BCRB_WAIT);
      w[`BCRB_ST_RDERR] = s.rd_err_st;
      w[`BCRB_ST_WRERR] = s.wr_err_st;
      w[`BCRB_ST_RUN]   = s.run;
    end
    return w;
  endfunction

  // ========================================================
  // Next-state logic
  logic       hit;
  logic       wr;
  logic [5:0] idx;
  logic [7:0] ticks_nx;
  logic [7:0] wdat;

  always_comb
  begin
    s_d      = s_q;
    hit      = WB_I.cyc & WB_I.stb;
    idx      = WB_I.adr[7:2];
    wdat     = WB_I.dat[7:0];
    ticks_nx = s_q.ticks + 8'h01;
    // Event outputs live for one cycle only
    s_d.retry  = 1'b0;
    s_d.done   = 1'b0;
    s_d.rd_err = 1'b0;
    s_d.wr_err = 1'b0;

    // Ack one cycle after the strobe, read data captured with it
    s_d.ack = hit & ~s_q.ack;
    if (hit && !s_q.ack)
      s_d.rdat = rd_word(s_q, idx);
    // Writes land on the edge where the master sees ack
    wr = hit & WB_I.we & s_q.ack & WB_I.sel[0];
    if (wr)
    begin
      if (idx == `BCRB_OFS_MACH)
        s_d.mach = wdat[1:0];
      else if (idx == `BCRB_OFS_TOUT)
        s_d.tout = wdat;
      else if (idx == `BCRB_OFS_MONEY)
        s_d.money = wdat;
      else if (idx == `BCRB_OFS_PUNCT)
        s_d.punct = wdat[0];
      else if (idx == `BCRB_OFS_RDLIM)
        s_d.rd_lim = wdat[3:0];
      else if (idx == `BCRB_OFS_WRLIM)
        // Out-of-range limits clamp rather than wrap
        s_d.wr_lim = (wdat[2:0] > `BCRB_WRLIM_MAX) ? `BCRB_WRLIM_MAX
                                                   : wdat[2:0];
      else if (idx == `BCRB_OFS_MKLIM)
        s_d.mk_lim = wdat[1:0];
      else if (idx == `BCRB_OFS_STAT)
      begin
        // Write one to clear the sticky error flags
        if (wdat[`BCRB_ST_RDERR])
          s_d.rd_err_st = 1'b0;
        if (wdat[`BCRB_ST_WRERR])
          s_d.wr_err_st = 1'b0;
      end
    end

    // Idle print head: count 41 ms units up to the timeout
    if (PRINT_BUSY_I || s_q.tout == 8'h00)
    begin
      s_d.pre   = 24'h00_0000;
      s_d.ticks = 8'h00;
      s_d.vis   = 1'b0;
    end
    else if (!s_q.vis)
    begin
      if (s_q.pre >= PRE_LAST)
      begin
        s_d.pre   = 24'h00_0000;
        s_d.ticks = ticks_nx;
        s_d.vis   = (ticks_nx == s_q.tout);
      end
      else
        s_d.pre = s_q.pre + 24'h00_0001;
    end

    // Retry engine for cassette operations
    case (s_q.fsm)
      BCRB_IDLE:
      begin
        if (TAPE_I.start)
        begin
          s_d.fsm  = BCRB_WAIT;
          s_d.kind = TAPE_I.kind;
          s_d.cnt  = 4'h0;
          // Each kind takes its own limit only
          case (TAPE_I.kind)
            BCRB_OP_WRITE: s_d.lim = {1'b0, s_q.wr_lim};
            BCRB_OP_MARK:  s_d.lim = {2'b00, s_q.mk_lim};
            default:       s_d.lim = s_q.rd_lim;
          endcase
        end
      end
      BCRB_WAIT:
      begin
        if (TAPE_I.ok)
        begin
          s_d.done = 1'b1;
          s_d.fsm  = BCRB_IDLE;
        end
        else if (TAPE_I.fail)
        begin
          if (s_q.cnt < s_q.lim)
          begin
            s_d.cnt   = s_q.cnt + 4'h1;
            s_d.retry = 1'b1;
          end
          else
          begin
            // Allowance used up: declare the error
            s_d.fsm = BCRB_IDLE;
            if (s_q.kind == BCRB_OP_READ)
            begin
              s_d.rd_err    = 1'b1;
              s_d.rd_err_st = 1'b1;
            end
            else
            begin
              s_d.wr_err    = 1'b1;
              s_d.wr_err_st = 1'b1;
            end
          end
        end
      end
      default:
        s_d.fsm = BCRB_IDLE;
    endcase

    // First key only marks the program as running
    if (FIRST_KEY_I)
      s_d.run = 1'b1;

    // Generation/load applies defaults and overrides bus writes and the first key
    if (GEN_LOAD_I)
    begin
      s_d.base   = USER_BASE_I;
      s_d.limit  = USER_LIMIT_I;
      s_d.mach   = `BCRB_MACH_RST;
      // Older object files carry no timeout: feature disabled
      s_d.tout   = LEGACY_I ? 8'h00 : `BCRB_TOUT_RST;
      s_d.money  = `BCRB_MONEY_RST;
      s_d.punct  = `BCRB_PUNCT_RST;
      s_d.rd_lim = `BCRB_RDLIM_RST;
      s_d.wr_lim = `BCRB_WRLIM_RST;
      s_d.mk_lim = `BCRB_MKLIM_RST;
      s_d.run    = 1'b0;
    end
  end

  // ========================================================
  // State flops, frozen while the clock enable is low
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      s_q <= RST_S;
    else if (CE_I)
      s_q <= s_d;
  end

  // ========================================================
  // Outputs
  assign WB_O.ack      = s_q.ack;
  assign WB_O.dat      = s_q.rdat;
  assign TAPE_O.busy   = (s_q.fsm == BCRB_WAIT);
  assign TAPE_O.retry  = s_q.retry;
  assign TAPE_O.done   = s_q.done;
  assign TAPE_O.rd_err = s_q.rd_err;
  assign TAPE_O.wr_err = s_q.wr_err;
  assign CFG_O.base    = s_q.base;
  assign CFG_O.limit   = s_q.limit;
  assign CFG_O.mach    = s_q.mach;
  assign CFG_O.money   = s_q.money;
  assign CFG_O.punct   = s_q.punct;
  assign CFG_O.vis     = s_q.vis;

  // ========================================================
  // Assertions
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  // Ack never lasts two active cycles
  ack_single_a: assert property (CE_I && s_q.ack |=> !s_q.ack)
    else $error("ack held too long");

  // Load sets base and limit from the interpreter
  base_limit_load_a: assert property (
    CE_I && GEN_LOAD_I |=> s_q.base == $past(USER_BASE_I) &&
                           s_q.limit == $past(USER_LIMIT_I))
    else $error("base or limit not loaded");

  // Defaults after load
  load_defaults_a: assert property (
    CE_I && GEN_LOAD_I |=> s_q.mach == 2'h3 && s_q.money == 8'h24 &&
      s_q.punct == 1'b0 && s_q.rd_lim == 4'h6 &&
      s_q.wr_lim == 3'h4 && s_q.mk_lim == 2'h2)
    else $error("load defaults wrong");

  tout_default_a: assert property (
    CE_I && GEN_LOAD_I && !LEGACY_I |=> s_q.tout == 8'h1D)
    else $error("timeout default wrong");

  legacy_zero_a: assert property (
    CE_I && GEN_LOAD_I && LEGACY_I |=> s_q.tout == 8'h00)
    else $error("legacy load kept timeout");

  // Zero timeout keeps visibility mode off
  zero_no_vis_a: assert property (
    CE_I && s_q.tout == 8'h00 |=> !s_q.vis)
    else $error("visibility with zero timeout");

  // Visibility only rises once the unit count hits the timeout
  vis_rise_a: assert property (
    $rose(s_q.vis) |-> s_q.ticks == $past(s_q.tout) && !$past(PRINT_BUSY_I))
    else $error("visibility rose early");

  wr_clamp_a: assert property (s_q.wr_lim <= 3'h4)
    else $error("write limit above four");

  start_clear_a: assert property (
    CE_I && s_q.fsm == BCRB_IDLE && TAPE_I.start |=> s_q.cnt == 4'h0)
    else $error("retry count not cleared");

  mark_limit_a: assert property (
    CE_I && s_q.fsm == BCRB_IDLE && TAPE_I.start &&
    TAPE_I.kind == BCRB_OP_MARK |=> s_q.lim == {2'b00, $past(s_q.mk_lim)})
    else $error("mark used wrong limit");

  // Failure at the limit declares the error next cycle
  limit_error_a: assert property (
    CE_I && s_q.fsm == BCRB_WAIT && !TAPE_I.ok && TAPE_I.fail &&
    s_q.cnt == s_q.lim |=> (s_q.rd_err || s_q.wr_err) && !s_q.retry)
    else $error("no error after last retry");

  key_stable_a: assert property (
    CE_I && FIRST_KEY_I && !GEN_LOAD_I && !WB_I.we |=>
      $stable(s_q.mach) && $stable(s_q.tout) && $stable(s_q.rd_lim))
    else $error("first key changed config");

  // A strobe with ack low is answered at the next edge
  ack_answer_a: assert property (CE_I && WB_I.cyc && WB_I.stb && !s_q.ack |=> s_q.ack)
    else $error("strobe not acked");

  // A write lands on the edge at which ack is seen
  money_write_a: assert property (
    CE_I && WB_I.cyc && WB_I.stb && WB_I.we && WB_I.sel[0] && s_q.ack && !GEN_LOAD_I &&
    WB_I.adr[7:2] == `BCRB_OFS_MONEY |=> s_q.money == $past(WB_I.dat[7:0]))
    else $error("money write lost");

  // Only a load event may move the memory window
  window_hold_a: assert property (
    CE_I && !GEN_LOAD_I |=> $stable(s_q.base) && $stable(s_q.limit))
    else $error("memory window changed");

  // A busy print head drops visibility mode
  busy_no_vis_a: assert property (
    CE_I && PRINT_BUSY_I |=> !s_q.vis)
    else $error("visibility while printing");

  write_limit_a: assert property (
    CE_I && s_q.fsm == BCRB_IDLE && TAPE_I.start &&
    TAPE_I.kind == BCRB_OP_WRITE |=> s_q.lim == {1'b0, $past(s_q.wr_lim)})
    else $error("write used wrong limit");

  // A read error at the limit sets the sticky read flag even against a clear
  sticky_set_a: assert property (
    CE_I && s_q.fsm == BCRB_WAIT && !TAPE_I.ok && TAPE_I.fail &&
    s_q.cnt == s_q.lim && s_q.kind == BCRB_OP_READ |=> s_q.rd_err_st)
    else $error("read error not kept");

  // Main scenarios
  retry_seen_c: cover property (s_q.retry ##[1:20] s_q.done);
  rd_err_c:     cover property (s_q.rd_err);
  mark_err_c:   cover property (s_q.kind == BCRB_OP_MARK && s_q.wr_err);
  vis_c:        cover property ($rose(s_q.vis));
  clear_c:      cover property (s_q.ack && WB_I.we && WB_I.adr[7:2] == `BCRB_OFS_STAT);
endmodule

// File: test/bcrb_top_tb.sv
// Self-checking bench of the basic config bank
`timescale 1ns/1ps
`include "bcrb_params.svh"
module bcrb_top_tb;
  import bcrb_pkg::*;
  logic           CLOCK_I;
  logic           RST_N_I;
  logic           CE_I;
  logic           GEN_LOAD_I;
  logic           LEGACY_I;
  logic           FIRST_KEY_I;
  logic           PRINT_BUSY_I;
  logic [15:0]    USER_BASE_I;
  logic [15:0]    USER_LIMIT_I;
  bcrb_wb_req_t   WB_I;
  bcrb_wb_rsp_t   WB_O;
  bcrb_tape_req_t TAPE_I;
  bcrb_tape_rsp_t TAPE_O;
  bcrb_cfg_t      CFG_O;
  int             n_errors;
  int             compares;
  int             cycles;
  logic [31:0]    q;
  localparam int TK = 4;
  // Offsets and generation defaults of the writable fields
  localparam logic [7:0]  DADR [7] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  localparam logic [31:0] DVAL [7] = '{32'h3, 32'h1D, 32'h24, 32'h0, 32'h6, 32'h4, 32'h2};

  // ==========================================================
  // Device under test, timer shortened so the visibility wait stays brief
  bcrb_top #(.TICK_CYCLES(TK)) u_bcrb_top (
    .CLOCK_I      (CLOCK_I),
    .RST_N_I      (RST_N_I),
    .CE_I         (CE_I),
    .WB_I         (WB_I),
    .WB_O         (WB_O),
    .GEN_LOAD_I   (GEN_LOAD_I),
    .LEGACY_I     (LEGACY_I),
    .USER_BASE_I  (USER_BASE_I),
    .USER_LIMIT_I (USER_LIMIT_I),
    .FIRST_KEY_I  (FIRST_KEY_I),
    .PRINT_BUSY_I (PRINT_BUSY_I),
    .TAPE_I       (TAPE_I),
    .TAPE_O       (TAPE_O),
    .CFG_O        (CFG_O)
  );

  // ==========================================================
  // Clock, 4 ns period
  initial
  begin
    CLOCK_I = 1'b0;
    forever #2 CLOCK_I = ~CLOCK_I;
  end

  // Hang guard, far above the run length
  always @(posedge CLOCK_I)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ==========================================================
  // Classic single Wishbone cycle; held until ack is seen high at an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge CLOCK_I);
    WB_I <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    // Request stands until the edge at which ack is sampled high
    do
      @(posedge CLOCK_I);
    while (WB_O.ack !== 1'b1);
    r = WB_O.dat;
    WB_I <= '0;
    // Idle cycle lets a write settle before anything looks at it
    @(posedge CLOCK_I);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, q);
  endtask

  task automatic defaults();
    for (int i = 0; i < 7; i++)
      rd(DADR[i], DVAL[i], "default");
  endtask

  task automatic pulse_load(input logic leg);
    @(posedge CLOCK_I);
    GEN_LOAD_I <= 1'b1;
    LEGACY_I   <= leg;
    @(posedge CLOCK_I);
    GEN_LOAD_I <= 1'b0;
    LEGACY_I   <= 1'b0;
    @(posedge CLOCK_I);
  endtask

  // ==========================================================
  // One cassette operation: nf failed attempts, then success if allowed
  task automatic tape(input bcrb_op_t k, input int nf, input int lim, input logic rdc);
    logic [3:0] e;
    @(posedge CLOCK_I);
    TAPE_I <= '{start: 1'b1, kind: k, ok: 1'b0, fail: 1'b0};
    @(posedge CLOCK_I);
    TAPE_I.start <= 1'b0;
    for (int i = 0; i <= nf; i++)
    begin
      @(posedge CLOCK_I);
      chk("tape busy", 32'h1, {31'h0, TAPE_O.busy});
      TAPE_I.fail <= (i < nf);
      TAPE_I.ok   <= (i >= nf);
      @(posedge CLOCK_I);
      TAPE_I.fail <= 1'b0;
      TAPE_I.ok   <= 1'b0;
      // Pulse launched at the previous edge still stands here
      @(posedge CLOCK_I);
      if (i >= nf)
        e = 4'b1000;
      else if (i < lim)
        e = 4'b0100;
      else
        e = {2'b00, rdc, ~rdc};
      chk("tape done/retry/rderr/wrerr", {28'h0, e},
          {28'h0, TAPE_O.done, TAPE_O.retry, TAPE_O.rd_err, TAPE_O.wr_err});
      if (e != 4'b0100)
        break;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    RST_N_I      = 1'b0;
    CE_I         = 1'b1;
    GEN_LOAD_I   = 1'b0;
    LEGACY_I     = 1'b0;
    FIRST_KEY_I  = 1'b0;
    PRINT_BUSY_I = 1'b1;
    USER_BASE_I  = 16'h1234;
    USER_LIMIT_I = 16'hBEEF;
    WB_I         = '0;
    TAPE_I       = '0;
    repeat (4) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    defaults();
    // Load event captures the memory window; read-only places ignore writes
    pulse_load(1'b0);
    chk("cfg base", 32'h1234, {16'h0, CFG_O.base});
    chk("cfg limit", 32'hBEEF, {16'h0, CFG_O.limit});
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    rd(8'h00, 32'h1234, "base");
    rd(8'h04, 32'hBEEF, "limit");
    // Every language code, then other fields, clamp and unmapped place
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h08, m);
      chk("cfg mach", m, {30'h0, CFG_O.mach});
    end
    wr(8'h10, 32'h23);
    wr(8'h14, 32'h1);
    wr(8'h1C, 32'h7);
    rd(8'h10, 32'h23, "money");
    chk("cfg money", 32'h23, {24'h0, CFG_O.money});
    chk("cfg punct", 32'h1, {31'h0, CFG_O.punct});
    rd(8'h1C, 32'h4, "write limit clamp");
    wr(8'h30, 32'hFF);
    rd(8'h30, 32'h0, "unmapped");
    // Program key keeps configuration
    @(posedge CLOCK_I);
    FIRST_KEY_I <= 1'b1;
    @(posedge CLOCK_I);
    FIRST_KEY_I <= 1'b0;
    rd(8'h10, 32'h23, "money after key");
    wb(1'b0, 8'h24, 32'h0, q);
    chk("run bit", 32'h1, {31'h0, q[`BCRB_ST_RUN]});
    pulse_load(1'b0);
    defaults();
    pulse_load(1'b1);
    rd(8'h0C, 32'h0, "legacy timeout");
    // Visibility after 2 units of idle print head, cleared when busy
    wr(8'h0C, 32'h2);
    @(posedge CLOCK_I);
    PRINT_BUSY_I <= 1'b0;
    repeat (6) @(posedge CLOCK_I);
    chk("vis early", 32'h0, {31'h0, CFG_O.vis});
    repeat (6) @(posedge CLOCK_I);
    chk("vis", 32'h1, {31'h0, CFG_O.vis});
    PRINT_BUSY_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    chk("vis busy", 32'h0, {31'h0, CFG_O.vis});
    wr(8'h0C, 32'h0);
    PRINT_BUSY_I <= 1'b0;
    repeat (40) @(posedge CLOCK_I);
    chk("vis zero", 32'h0, {31'h0, CFG_O.vis});
    // Clock enable low: a load event must leave the fields untouched
    CE_I <= 1'b0;
    pulse_load(1'b0);
    CE_I <= 1'b1;
    rd(8'h0C, 32'h0, "timeout while frozen");
    // Retry engine: each kind with its own limit
    wr(8'h18, 32'h2);
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h1);
    tape(BCRB_OP_READ, 3, 2, 1'b1);
    tape(BCRB_OP_READ, 2, 2, 1'b1);
    tape(BCRB_OP_WRITE, 1, 0, 1'b0);
    tape(BCRB_OP_MARK, 2, 1, 1'b0);
    tape(BCRB_OP_MARK, 1, 1, 1'b0);
    // Program doing its own read retries: first failure is final
    wr(8'h18, 32'h0);
    tape(BCRB_OP_READ, 1, 0, 1'b1);
    wb(1'b0, 8'h24, 32'h0, q);
    chk("sticky errors", 32'h3, {30'h0, q[`BCRB_ST_WRERR], q[`BCRB_ST_RDERR]});
    wr(8'h24, 32'hC);
    rd(8'h24, 32'h0, "status cleared");
    results();
  end
endmodule
